// >>> src/rsc_pkg.sv
/*
 * reset source controller package: register map, field positions, reset values,
 * timing constants, sequencer states and the grouped port structs.
 * assumes a single 200 MHz clock and a classic wishbone register bus.
 */
package rsc_pkg;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned BOR_CLEAR_US     = 500;
    localparam int unsigned BOR_CLEAR_CYC    = BOR_CLEAR_US * CLK_MHZ;
    localparam int unsigned SYNC_STAGES      = 2;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CAUSE        = 8'h00;
    localparam logic [7:0] ADDR_BOR_CTL      = 8'h04;
    localparam logic [7:0] ADDR_APP_RST      = 8'h08;
    localparam logic [7:0] ADDR_PERIPH_RST   = 8'h0c;
    localparam logic [7:0] ADDR_PIN_ALT      = 8'h10;
    localparam logic [7:0] ADDR_STATUS       = 8'h14;
    localparam logic [7:0] ADDR_IDENT_A      = 8'h20;
    localparam logic [7:0] ADDR_IDENT_B      = 8'h24;
    localparam logic [7:0] ADDR_CAP0         = 8'h28;
    localparam int unsigned NUM_CAP          = 5;

    // ------------------------------------------------------------------
    // fields
    // ------------------------------------------------------------------
    localparam int unsigned CAUSE_EXT        = 0;
    localparam int unsigned CAUSE_POR        = 1;
    localparam int unsigned CAUSE_BOR        = 2;
    localparam int unsigned CAUSE_WDT        = 3;
    localparam int unsigned CAUSE_SW         = 4;
    localparam int unsigned CAUSE_LDO        = 5;
    localparam int unsigned CAUSE_W          = 6;
    localparam int unsigned BCTL_RESAMPLE    = 0;
    localparam int unsigned BCTL_RST_EN      = 1;
    localparam int unsigned BCTL_INT_EN      = 2;
    localparam int unsigned BCTL_LDO_EN      = 3;
    localparam int unsigned BCTL_DLY_LSB     = 8;
    localparam int unsigned DLY_W            = 16;
    localparam int unsigned APP_SYSREQ       = 2;
    localparam int unsigned NUM_PERIPH       = 8;

    // ------------------------------------------------------------------
    // values after reset; identification values are arbitrary
    // ------------------------------------------------------------------
    localparam logic [3:0]       BCTL_RESET  = 4'h0;
    localparam logic [DLY_W-1:0] DLY_RESET   = 16'h0000;
    localparam logic [31:0]      IDENT_A_VAL = 32'h00a5_0001;
    localparam logic [31:0]      IDENT_B_VAL = 32'h0011_2233;
    localparam logic [31:0]      CAP_VAL     = 32'h0000_0001;
    localparam logic [CAUSE_W-1:0] CAUSE_RESET = 6'h02;

    typedef enum logic [3:0] {
        RSC_RUN   = 4'b0001,
        RSC_HOLD  = 4'b0010,
        RSC_SYNC  = 4'b0100,
        RSC_FETCH = 4'b1000
    } rsc_state_t;

    typedef struct packed {
        logic                  cyc;
        logic                  stb;
        logic                  we;
        logic [3:0]            sel;
        logic [7:0]            adr;
        logic [31:0]           dat;
    } rsc_wb_req_t;

    typedef struct packed {
        logic                  core;
        logic [NUM_PERIPH-1:0] periph;
        logic                  tap;
        logic                  tap_pin_cfg;
    } rsc_domains_t;

endpackage

// >>> src/rsc_top.sv
/*
 * reset source controller: gathers the six reset sources, drives the core,
 * peripheral and debug tap resets, sequences release and vector fetch, keeps
 * sticky cause bits and runs the brown-out resample / hold-off filter.
 * assumes rst_i is the power-on detector output synchronous to clk_i, all other
 * inputs synchronous to clk_i, and a classic wishbone master on the bus.
 */
`timescale 1ns/1ps

module rsc_top
    import rsc_pkg::*;
#(
    parameter int unsigned BOR_HOLD_CYC = BOR_CLEAR_CYC
) (
    input  wire logic                  clk_i,
    input  wire logic                  rst_i,
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [31:0]           wb_dat_i,
    output logic      [31:0]           wb_dat_o,
    output logic                       wb_ack_o,
    input  wire logic                  rst_pin_n_i,
    input  wire logic                  brownout_detect_i,
    input  wire logic                  watchdog_reset_i,
    input  wire logic                  core_regulator_unreg_i,
    input  wire logic                  nmi_pad_i,
    output logic                       core_rst_o,
    output logic      [NUM_PERIPH-1:0] periph_rst_o,
    output logic                       tap_rst_o,
    output logic                       tap_pin_cfg_rst_o,
    output logic                       fetch_vectors_o,
    output logic                       brownout_int_o,
    output logic                       nmi_o,
    output logic                       gpio_in_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        rsc_state_t            st;
        logic [1:0]            sync_cnt;
        logic                  por_phase;
        logic [CAUSE_W-1:0]    cause;
        logic [3:0]            bctl;
        logic [DLY_W-1:0]      dly;
        logic [NUM_PERIPH-1:0] periph;
        logic                  nmi_sel;
        logic                  bor_prev;
        logic [16:0]           holdoff;
        logic                  resampling;
        logic [DLY_W-1:0]      resample_cnt;
        logic                  bor_int_flag;
        logic                  int_pulse;
        logic                  ack;
        logic [31:0]           dat;
    } rsc_regs_t;

    rsc_regs_t   r;
    rsc_regs_t   next_r;
    rsc_wb_req_t req;
    rsc_domains_t dom;

    localparam logic [16:0] HOLD_LOAD = 17'(BOR_HOLD_CYC);

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // control word in its bus layout: enables low, resample delay above
    function automatic logic [31:0] pack_ctl(input logic [3:0]       bctl,
                                             input logic [DLY_W-1:0] dly);
        return {8'h00, dly, 4'h0, bctl};
    endfunction

    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i,
                   sel: wb_sel_i, adr: wb_adr_i, dat: wb_dat_i};

    // ------------------------------------------------------------------
    // source decode
    // ------------------------------------------------------------------
    logic bus_wr;
    logic bus_rd;
    logic ext_src;
    logic sw_src;
    logic ldo_src;
    logic bor_rise;
    logic bor_armed;
    logic bor_rst_src;
    logic bor_int_now;
    logic resample_hit;
    logic any_src;
    logic [CAUSE_W-1:0] cause_set;
    logic [31:0] wr_merged;
    logic [31:0] ctl_merged;
    logic [31:0] periph_merged;

    assign bus_wr    = req.cyc & req.stb & req.we & ~r.ack;
    assign bus_rd    = req.cyc & req.stb & ~req.we & ~r.ack;
    assign ext_src   = ~rst_pin_n_i;
    assign sw_src    = bus_wr & (req.adr == ADDR_APP_RST) & req.sel[0]
                       & req.dat[APP_SYSREQ];
    // regulator loss resets only once software has enabled it
    assign ldo_src   = core_regulator_unreg_i & r.bctl[BCTL_LDO_EN];
    // new detector edges are ignored during the hold-off window
    assign bor_rise  = brownout_detect_i & ~r.bor_prev & (r.holdoff == '0);
    // the resample, reset or interrupt enable arms the detector; with all three clear it is ignored
    assign bor_armed = |r.bctl[BCTL_INT_EN:BCTL_RESAMPLE];
    assign bor_rst_src = bor_rise & r.bctl[BCTL_RST_EN];
    assign resample_hit = r.resampling & (r.resample_cnt == '0);
    // the controller interrupt only fires when reset is not enabled
    assign bor_int_now = ~r.bctl[BCTL_RST_EN] & r.bctl[BCTL_INT_EN] &
                         ((bor_rise & ~r.bctl[BCTL_RESAMPLE]) |
                          (resample_hit & brownout_detect_i));
    assign any_src   = ext_src | sw_src | watchdog_reset_i | ldo_src | bor_rst_src;

    always_comb begin
        cause_set = '0;
        cause_set[CAUSE_EXT] = ext_src;
        cause_set[CAUSE_BOR] = bor_rst_src;
        cause_set[CAUSE_WDT] = watchdog_reset_i;
        cause_set[CAUSE_SW]  = sw_src;
        cause_set[CAUSE_LDO] = ldo_src;
    end

    assign wr_merged = merge_bytes(32'h0000_0000, req.dat, req.sel);

    // ------------------------------------------------------------------
    // byte-lane merges for the writable control words
    // ------------------------------------------------------------------
    // the control word is rebuilt in its bus layout so one merge serves
    // both the enable bits and the resample delay
    assign ctl_merged    = merge_bytes(pack_ctl(r.bctl, r.dly), req.dat, req.sel);
    assign periph_merged = merge_bytes(32'(r.periph), req.dat, req.sel);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.int_pulse = 1'b0;
        next_r.bor_prev  = brownout_detect_i;

        // sequencer: any source forces hold, release goes through sync stages
        unique case (r.st)
            RSC_RUN: begin
                if (any_src) begin
                    next_r.st = RSC_HOLD;
                end
            end
            RSC_HOLD: begin
                // the pin arrives clean; holding it low long enough is the board's duty
                if (!any_src) begin
                    next_r.st = RSC_SYNC;
                    next_r.sync_cnt = 2'(SYNC_STAGES - 1);
                end
            end
            RSC_SYNC: begin
                if (any_src) begin
                    next_r.st = RSC_HOLD;
                end else if (r.sync_cnt == '0) begin
                    next_r.st = RSC_FETCH;
                end else begin
                    next_r.sync_cnt = r.sync_cnt - 2'h1;
                end
            end
            RSC_FETCH: begin
                next_r.st = any_src ? RSC_HOLD : RSC_RUN;
                // the tap leaves reset here; only a new power-on brings it back
                next_r.por_phase = 1'b0;
            end
        endcase

        // brownout filter and hold-off
        // a disarmed detector loads no hold-off, so arming it later sees the next edge
        if (r.holdoff != '0) begin
            next_r.holdoff = r.holdoff - 17'h1;
        end
        if (bor_rise && bor_armed) begin
            next_r.holdoff = HOLD_LOAD;
            if (r.bctl[BCTL_RESAMPLE] && !r.bctl[BCTL_RST_EN]) begin
                next_r.resampling   = 1'b1;
                next_r.resample_cnt = r.dly;
            end
        end else if (r.resampling) begin
            if (r.resample_cnt == '0) begin
                next_r.resampling = 1'b0;
            end else begin
                next_r.resample_cnt = r.resample_cnt - 16'h1;
            end
        end
        if (bor_int_now) begin
            next_r.int_pulse = 1'b1;
        end

        // bus and registers
        // registered ack: one wait state on every access, no address ever stalls
        next_r.ack = req.cyc & req.stb & ~r.ack;
        if (bus_rd) begin
            unique case (req.adr)
                ADDR_CAUSE:      next_r.dat = 32'(r.cause);
                ADDR_BOR_CTL:    next_r.dat = pack_ctl(r.bctl, r.dly);
                ADDR_APP_RST:    next_r.dat = 32'h0000_0000;
                ADDR_PERIPH_RST: next_r.dat = 32'(r.periph);
                ADDR_PIN_ALT:    next_r.dat = 32'(r.nmi_sel);
                ADDR_STATUS:     next_r.dat = {28'h0000000, r.resampling, r.bor_int_flag,
                                               r.por_phase, brownout_detect_i};
                ADDR_IDENT_A:    next_r.dat = IDENT_A_VAL;
                ADDR_IDENT_B:    next_r.dat = IDENT_B_VAL;
                default: begin
                    // all capability words read alike; unaligned offsets read zero
                    if (req.adr >= ADDR_CAP0 && req.adr < ADDR_CAP0 + 8'(4 * NUM_CAP)
                        && req.adr[1:0] == 2'b00) begin
                        next_r.dat = CAP_VAL;
                    end else begin
                        next_r.dat = 32'h0000_0000;
                    end
                end
            endcase
        end

        if (bus_wr) begin
            unique case (req.adr)
                ADDR_CAUSE: begin
                    next_r.cause = r.cause & ~wr_merged[CAUSE_W-1:0];
                end
                ADDR_BOR_CTL: begin
                    next_r.bctl = ctl_merged[BCTL_LDO_EN:BCTL_RESAMPLE];
                    next_r.dly  = ctl_merged[BCTL_DLY_LSB +: DLY_W];
                end
                ADDR_PERIPH_RST: begin
                    next_r.periph = periph_merged[NUM_PERIPH-1:0];
                end
                ADDR_PIN_ALT: begin
                    next_r.nmi_sel = req.sel[0] ? req.dat[0] : r.nmi_sel;
                end
                ADDR_STATUS: begin
                    // bit 2 clears the interrupt flag; the other bits are live views
                    if (wr_merged[2]) begin
                        next_r.bor_int_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (bor_int_now) begin
            next_r.bor_int_flag = 1'b1;
        end

        // cause capture after bus clear so a new event wins the clear
        if (ext_src) begin
            next_r.cause = '0;
            next_r.cause[CAUSE_EXT] = 1'b1;
        end else begin
            next_r.cause = next_r.cause | cause_set;
        end

        // a system reset returns the soft peripheral selects to idle
        if (r.st == RSC_HOLD) begin
            next_r.periph = '0;
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    // one clock serves both oscillator roles; there is no clock switch here,
    // so pin and power-on handling share the sequencer's clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.st        <= RSC_HOLD;
            r.por_phase <= 1'b1;
            r.cause     <= CAUSE_RESET;
            r.bctl      <= BCTL_RESET;
            r.dly       <= DLY_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    // reset asserts combinationally from its source so no clock is needed to
    // enter reset; release waits for the registered sequencer
    logic sys_rst;
    assign sys_rst = rst_i | any_src | (r.st == RSC_HOLD) | (r.st == RSC_SYNC);

    always_comb begin
        dom.core        = sys_rst;
        dom.periph      = {NUM_PERIPH{sys_rst}} | r.periph;
        dom.tap         = rst_i | (r.por_phase & (r.st != RSC_RUN));
        dom.tap_pin_cfg = dom.tap | ext_src;
    end

    assign core_rst_o        = dom.core;
    assign periph_rst_o      = dom.periph;
    assign tap_rst_o         = dom.tap;
    assign tap_pin_cfg_rst_o = dom.tap_pin_cfg;
    assign fetch_vectors_o   = (r.st == RSC_FETCH);
    assign brownout_int_o    = r.int_pulse;
    // with the select clear the pad is plain gpio and can never raise nmi
    assign nmi_o             = r.nmi_sel & nmi_pad_i;
    assign gpio_in_o         = ~r.nmi_sel & nmi_pad_i;
    assign wb_ack_o          = r.ack;
    assign wb_dat_o          = r.dat;

endmodule // rsc_top

// >>> tb/rsc_pin_model.sv
/*
 * board reset switch with pull-up driving the active-low reset pin.
 * assumes press_i comes from the bench; a press always holds the pin low for at least MIN_LOW cycles.
 */
`timescale 1ns/1ps

module rsc_pin_model #(
    parameter int MIN_LOW = 4
) (
    input  wire logic clk_i,
    input  wire logic press_i,
    output logic      rst_pin_n_o
);
    int   low_cnt = 0;
    logic low_q   = 1'b0;

    // a short tap is stretched so the pin never goes back high too early
    always @(posedge clk_i) begin
        if (press_i || (low_cnt > 0 && low_cnt < MIN_LOW)) begin
            low_q   <= 1'b1;
            low_cnt <= low_cnt + 1;
        end else begin
            low_q   <= 1'b0;
            low_cnt <= 0;
        end
    end

    // pull-up holds the released pin high
    assign rst_pin_n_o = ~low_q;
endmodule // rsc_pin_model

// >>> tb/rsc_top_assertions.sv
/*
 * concurrent checks on the reset source controller ports, bound into rsc_top.
 * assumes one clock domain, clk_i, with rst_i as the synchronous power-on reset.
 */
`timescale 1ns/1ps

module rsc_checker
    import rsc_pkg::*;
(
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_ack_o,
    input wire logic                  rst_pin_n_i,
    input wire logic                  brownout_detect_i,
    input wire logic                  watchdog_reset_i,
    input wire logic                  core_regulator_unreg_i,
    input wire logic                  nmi_pad_i,
    input wire logic                  core_rst_o,
    input wire logic [NUM_PERIPH-1:0] periph_rst_o,
    input wire logic                  tap_rst_o,
    input wire logic                  tap_pin_cfg_rst_o,
    input wire logic                  fetch_vectors_o,
    input wire logic                  brownout_int_o,
    input wire logic                  nmi_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not acknowledged on the next edge");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack stood longer than one cycle");
    a_pin_resets: assert property (!rst_pin_n_i |-> core_rst_o && (&periph_rst_o) && tap_pin_cfg_rst_o)
        else $error("pin low without core, peripheral and pin config reset");
    a_tap_no_recur: assert property (!tap_rst_o |=> !tap_rst_o)
        else $error("tap reset rose outside power-on");
    a_sys_periph: assert property (core_rst_o |-> &periph_rst_o)
        else $error("system reset left a peripheral running");
    a_wdt_core: assert property (watchdog_reset_i |-> core_rst_o)
        else $error("watchdog request did not reset the core at once");
    a_pin_fetch: assert property ($rose(rst_pin_n_i) && !watchdog_reset_i && !brownout_detect_i
        && !core_regulator_unreg_i |-> ##[1:6] fetch_vectors_o)
        else $error("no vector fetch after pin release");
    a_fetch_single: assert property (fetch_vectors_o |=> !fetch_vectors_o)
        else $error("vector fetch pulse longer than one cycle");
    a_int_single: assert property (brownout_int_o |=> !brownout_int_o)
        else $error("brown-out interrupt pulse longer than one cycle");
    a_nmi_gated: assert property (nmi_o |-> nmi_pad_i)
        else $error("nmi raised without the pad");

    c_pin: cover property ($rose(rst_pin_n_i) ##[1:6] fetch_vectors_o);
    c_int: cover property (brownout_int_o);
    c_wdt: cover property (watchdog_reset_i && core_rst_o);
endmodule // rsc_checker

bind rsc_top rsc_checker rsc_checker_i (.*);

// >>> tb/test_rsc_top.sv
/*
 * self-checking bench for rsc_top: power-on, pin, system and soft resets,
 * brown-out filter, nmi select and register reads over classic wishbone.
 * assumes the pin model and checker files are compiled before this one.
 */
`timescale 1ns/1ps

module test_rsc_top
    import rsc_pkg::*;
;
    localparam int HOLD = 50;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic press = 1'b0, bor = 1'b0, wdt = 1'b0, core_regulator = 1'b0, pad = 1'b0;
    logic [7:0]  adr  = 8'h00;
    logic [31:0] wdat = 32'h0000_0000, rdata, wb_dat;
    logic        wb_ack, pin_n, core, tap, tap_cfg, fetch, bor_int, nmi, gpio;
    logic [7:0]  periph;
    logic [5:0]  bit_of [4] = '{6'h08, 6'h10, 6'h20, 6'h04};
    logic [31:0] exp_cause;
    int miscompares = 0, n_compared = 0, n_int = 0, n_core = 0;

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        if (bor_int === 1'b1) n_int++;
        if (core === 1'b1) n_core++;
    end

    rsc_pin_model #(.MIN_LOW(4)) rsc_pin_model_i (.clk_i(clk_i), .press_i(press), .rst_pin_n_o(pin_n));
    rsc_top #(.BOR_HOLD_CYC(HOLD)) rsc_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack),
        .rst_pin_n_i(pin_n), .brownout_detect_i(bor), .watchdog_reset_i(wdt), .core_regulator_unreg_i(core_regulator),
        .nmi_pad_i(pad), .core_rst_o(core), .periph_rst_o(periph), .tap_rst_o(tap),
        .tap_pin_cfg_rst_o(tap_cfg), .fetch_vectors_o(fetch), .brownout_int_o(bor_int), .nmi_o(nmi),
        .gpio_in_o(gpio));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task chk1(input logic seen, input logic exp);
        check({31'h0, seen}, {31'h0, exp});
    endtask

    // one classic cycle; held until ack is sampled, then a cycle idle; a hang ends at the watchdog
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        rdata = wb_dat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    endtask

    task rd(input logic [7:0] a);
        wb(1'b0, a, 32'h0);
    endtask

    task wait_fetch;
        int n;
        n = 0;
        while (fetch !== 1'b1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        chk1(n < 40, 1'b1);
        @(posedge clk_i);
    endtask

    task pulse(input int s, input int n);
        @(posedge clk_i);
        case (s)
            0: bor <= 1'b1;
            1: wdt <= 1'b1;
            default: core_regulator <= 1'b1;
        endcase
        repeat (n) @(posedge clk_i);
        bor <= 1'b0; wdt <= 1'b0; core_regulator <= 1'b0;
    endtask

    task give_verdict;
        if (miscompares == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task t_power_on;
        @(posedge clk_i);
        #1;
        chk1(tap & core, 1'b1);
        wait_fetch();
        chk1(tap, 1'b0);
        rd(ADDR_CAUSE); check(rdata, 32'h2);
        rd(ADDR_BOR_CTL); check(rdata, 32'h0);
        wb(1'b1, ADDR_IDENT_A, 32'hffff_ffff);
        rd(ADDR_IDENT_A); check(rdata, IDENT_A_VAL);
        rd(ADDR_CAP0 + 8'h10); check(rdata, CAP_VAL);
        rd(8'h40); check(rdata, 32'h0);
    endtask

    task t_soft_nmi;
        n_core = 0;
        pad <= 1'b1;
        wb(1'b1, ADDR_PERIPH_RST, 32'ha5);
        check({24'h0, periph}, 32'ha5);
        wb(1'b1, ADDR_PERIPH_RST, 32'h0);
        check({24'h0, periph}, 32'h0);
        check(n_core, 0);
        chk1(nmi | ~gpio, 1'b0);
        wb(1'b1, ADDR_PIN_ALT, 32'h1);
        chk1(nmi, 1'b1);
        chk1(gpio, 1'b0);
    endtask

    task t_bor_filter;
        n_int = 0; n_core = 0;
        pulse(0, 5); repeat (10) @(posedge clk_i);
        check(n_int, 0);
        wb(1'b1, ADDR_BOR_CTL, 32'h4);
        pulse(0, 5); repeat (10) @(posedge clk_i);
        check(n_int, 1);
        rd(ADDR_STATUS); check(rdata, 32'h4);
        wb(1'b1, ADDR_STATUS, 32'h4);
        rd(ADDR_STATUS); check(rdata, 32'h0);
        repeat (HOLD) @(posedge clk_i);
        wb(1'b1, ADDR_BOR_CTL, 32'h0000_0a05);
        n_int = 0;
        pulse(0, 3); repeat (30) @(posedge clk_i);
        check(n_int, 0);
        repeat (HOLD) @(posedge clk_i);
        pulse(0, 20); pulse(0, 20); repeat (15) @(posedge clk_i);
        check(n_int, 1);
        check(n_core, 0);
        repeat (HOLD) @(posedge clk_i);
    endtask

    task t_pin;
        @(posedge clk_i);
        press <= 1'b1;
        repeat (3) @(posedge clk_i);
        press <= 1'b0;
        #1;
        check({core, tap, tap_cfg}, 3'b101);
        wait_fetch();
        rd(ADDR_CAUSE); check(rdata, 32'h1);
    endtask

    // watchdog, software request, regulator and brown-out, in turn
    task t_sys_sources;
        exp_cause = 32'h1;
        n_int = 0;
        wb(1'b1, ADDR_BOR_CTL, 32'ha);
        for (int i = 0; i < 4; i++) begin
            n_core = 0;
            case (i)
                0: pulse(1, 4);
                1: wb(1'b1, ADDR_APP_RST, 32'h4);
                2: pulse(2, 4);
                default: pulse(0, 4);
            endcase
            wait_fetch();
            chk1(n_core > 0, 1'b1);
            exp_cause = exp_cause | {26'h0, bit_of[i]};
            rd(ADDR_CAUSE); check(rdata, exp_cause);
        end
        check(n_int, 0);
    endtask

    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        t_power_on();
        t_soft_nmi();
        t_bor_filter();
        t_pin();
        t_sys_sources();
        give_verdict();
    end

    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end
endmodule // test_rsc_top
